// [rtl/ext_irq_pkg.sv]
// constants for the external pin interrupt sense block
package ext_irq_pkg;
	// register indices (printed offsets are not all multiples of four)
	localparam logic [7:0] IDX_MCU_CONTROL    = 8'h35;
	localparam logic [7:0] IDX_EXT_IRQ_FLAGS  = 8'h3A;
	localparam logic [7:0] IDX_EXT_IRQ_ENABLES = 8'h3B;
	localparam logic [7:0] IDX_PIN_CHANGE_SEL = 8'h3C;
	localparam logic [7:0] IDX_IRQ_STATUS     = 8'h3D;
	localparam logic [7:0] IDX_IRQ_MASK       = 8'h3E;
	localparam logic [7:0] IDX_CORE_STATUS    = 8'h3F;
	localparam logic [9:0] ADDR_MCU_CONTROL    = {IDX_MCU_CONTROL, 2'b00};
	localparam logic [9:0] ADDR_EXT_IRQ_FLAGS  = {IDX_EXT_IRQ_FLAGS, 2'b00};
	localparam logic [9:0] ADDR_EXT_IRQ_ENABLES = {IDX_EXT_IRQ_ENABLES, 2'b00};
	localparam logic [9:0] ADDR_PIN_CHANGE_SEL = {IDX_PIN_CHANGE_SEL, 2'b00};
	localparam logic [9:0] ADDR_IRQ_STATUS     = {IDX_IRQ_STATUS, 2'b00};
	localparam logic [9:0] ADDR_IRQ_MASK       = {IDX_IRQ_MASK, 2'b00};
	localparam logic [9:0] ADDR_CORE_STATUS    = {IDX_CORE_STATUS, 2'b00};
	// field positions
	localparam int SENSE_SEL_LO_BIT    = 0;
	localparam int SENSE_SEL_HI_BIT    = 1;
	localparam int PIN_CHANGE_FLAG_BIT = 5;
	localparam int EXT_IRQ_FLAG_BIT    = 6;
	localparam int GLOBAL_IE_BIT       = 7;
	localparam int PIN_CHANGE_COUNT    = 6;
	// reset values
	localparam logic [7:0] RESET_BYTE  = 8'h00;
	localparam logic [1:0] RESET_SENSE = 2'h0;
	// vector numbers and program addresses
	localparam logic [3:0]  VEC_NUM_EXT_PIN    = 4'h2;
	localparam logic [3:0]  VEC_NUM_PIN_CHANGE = 4'h3;
	localparam logic [15:0] VEC_ADDR_EXT_PIN    = 16'h0001;
	localparam logic [15:0] VEC_ADDR_PIN_CHANGE = 16'h0002;
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// sense modes
	typedef enum logic [1:0] {
		SENSE_LOW  = 2'h0,
		SENSE_ANY  = 2'h1,
		SENSE_FALL = 2'h2,
		SENSE_RISE = 2'h3
	} sense_mode_t;
endpackage

// [rtl/pin_sync_edge.sv]
// two-flop synchronizer with change detector for one pin
`timescale 1ns/100ps
`default_nettype none
module pin_sync_edge
	import ext_irq_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic pinAsync,
	output logic      pinSync,
	output logic      rose,
	output logic      fell
);
	logic metaReg;
	logic syncReg;
	logic prevReg;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			metaReg <= 1'b0;
			syncReg <= 1'b0;
			prevReg <= 1'b0;
		end else begin
			metaReg <= pinAsync;
			syncReg <= metaReg;
			prevReg <= syncReg;
		end
	end

	// compare against previous synchronised sample only
	assign pinSync = syncReg;
	assign rose    = syncReg & ~prevReg;
	assign fell    = ~syncReg & prevReg;
endmodule // pin_sync_edge
`default_nettype wire

// [rtl/ext_pin_interrupt_sense.sv]
// external pin interrupt sense and pin-change logic with AXI4-Lite registers
//Contract
// - sense bits choose low level, any change, falling or rising edge
// - dedicated pin request needs global enable and its own mask bit
// - pin sampled before edge detect; pulses over one clock always caught
// - pin activity requests even when the pin is an output
// - pin-change interrupt on any change of an enabled pin, when enabled
// - triggering edge or change sets dedicated pin flag; vectors when enabled
// - change on enabled pin sets pin-change flag; vectors when enabled
// - flags clear on handler entry or on writing one; zero ignored
// - dedicated pin flag held cleared in low-level mode
// - six mask bits select which pins join the pin-change interrupt
// - reserved bits read zero and ignore writes
// - low-level request stays asserted while the pin is held low
// - level and pin-change detection work without the edge clock path; here both run off sys_clk through the pin synchronisers
// - vector 2 at 0x0001 for dedicated pin, 3 at 0x0002 for pin change
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module ext_pin_interrupt_sense
	import ext_irq_pkg::*;
(
	input  wire logic                        sys_clk,
	input  wire logic                        rst,
	input  wire logic                        extIrqPin,
	input  wire logic [PIN_CHANGE_COUNT-1:0] pinChangeInputs,
	input  wire logic                        extVecAck,
	input  wire logic                        pinChangeVecAck,
	output logic                             extIrqRequest,
	output logic                             pinChangeRequest,
	output logic [3:0]                       vecNumber,
	output logic [15:0]                      vecAddress,
	output logic                             irq,
	input  wire logic [11:0]                 s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [11:0]                 s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready
);
	logic [1:0]                  senseSel_reg;
	logic                        extEnable_reg;
	logic                        pcEnable_reg;
	logic                        globalIe_reg;
	logic [PIN_CHANGE_COUNT-1:0] pinChangeSelect_reg;
	logic                        extFlag_reg;
	logic                        pcFlag_reg;
	logic [1:0]                  irqStatus_reg;
	logic [1:0]                  irqMask_reg;
	logic [3:0]                  vecNumber_reg;
	logic [15:0]                 vecAddress_reg;

	logic                        extSync;
	logic                        extRose;
	logic                        extFell;
	logic [PIN_CHANGE_COUNT-1:0] pcRose;
	logic [PIN_CHANGE_COUNT-1:0] pcFell;
	logic [PIN_CHANGE_COUNT:0]   syncTaps;

	// AXI write and read side
	logic        awHeld_reg;
	logic [9:0]  awAddr_reg;
	logic        wHeld_reg;
	logic [7:0]  wData_reg;
	logic        wLane0_reg;
	logic        bValid_reg;
	logic [1:0]  bResp_reg;
	logic        rValid_reg;
	logic [31:0] rData_reg;
	logic [1:0]  rResp_reg;
	logic        doWrite;
	logic        wrEn;
	logic        arTake;
	logic [7:0]  readByte;
	logic        readHit;

	// synchronise the dedicated pin, whatever the pin direction
	pin_sync_edge extSyncInst (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.pinAsync (extIrqPin),
		.pinSync  (extSync),
		.rose     (extRose),
		.fell     (extFell)
	);

	genvar gi;
	generate
		for (gi = 0; gi < PIN_CHANGE_COUNT; gi++) begin : gPinChange
			pin_sync_edge pcSyncInst (
				.sys_clk  (sys_clk),
				.rst      (rst),
				.pinAsync (pinChangeInputs[gi]),
				.pinSync  (syncTaps[gi]),
				.rose     (pcRose[gi]),
				.fell     (pcFell[gi])
			);
		end
	endgenerate
	assign syncTaps[PIN_CHANGE_COUNT] = extSync;

	// trigger conditions
	logic        extEdgeHit;
	logic        lowLevelMode;
	logic        lowLevelActive;
	logic        pcHit;
	sense_mode_t senseMode;

	assign senseMode    = sense_mode_t'(senseSel_reg);
	assign lowLevelMode = (senseMode == SENSE_LOW);
	// level is combinational from the synchronised pin; no edge history needed
	assign lowLevelActive = lowLevelMode & ~extSync;

	always_comb begin
		case (senseMode)
			SENSE_ANY:  extEdgeHit = extRose | extFell;
			SENSE_FALL: extEdgeHit = extFell;
			SENSE_RISE: extEdgeHit = extRose;
			default:    extEdgeHit = 1'b0;
		endcase
	end

	// change detection is per pin, no clock-gated path beyond the sync
	assign pcHit = |((pcRose | pcFell) & pinChangeSelect_reg);

	assign doWrite = awHeld_reg & wHeld_reg & ~bValid_reg;
	assign wrEn    = doWrite & wLane0_reg;

	// dedicated pin flag: set beats clear
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			extFlag_reg <= 1'b0;
		end else if (lowLevelMode) begin
			extFlag_reg <= 1'b0;
		end else if (extEdgeHit) begin
			extFlag_reg <= 1'b1;
		end else if (extVecAck) begin
			extFlag_reg <= 1'b0;
		end else if (wrEn && awAddr_reg == ADDR_EXT_IRQ_FLAGS && wData_reg[EXT_IRQ_FLAG_BIT]) begin
			extFlag_reg <= 1'b0;
		end
	end

	// pin-change flag: set beats clear
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pcFlag_reg <= 1'b0;
		end else if (pcHit) begin
			pcFlag_reg <= 1'b1;
		end else if (pinChangeVecAck) begin
			pcFlag_reg <= 1'b0;
		end else if (wrEn && awAddr_reg == ADDR_EXT_IRQ_FLAGS && wData_reg[PIN_CHANGE_FLAG_BIT]) begin
			pcFlag_reg <= 1'b0;
		end
	end

	// requests toward the core
	assign extIrqRequest    = globalIe_reg & extEnable_reg & (extFlag_reg | lowLevelActive);
	assign pinChangeRequest = globalIe_reg & pcEnable_reg & pcFlag_reg;

	// vector encoder, dedicated pin has priority
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			vecNumber_reg  <= 4'h0;
			vecAddress_reg <= 16'h0000;
		end else if (extIrqRequest) begin
			vecNumber_reg  <= VEC_NUM_EXT_PIN;
			vecAddress_reg <= VEC_ADDR_EXT_PIN;
		end else if (pinChangeRequest) begin
			vecNumber_reg  <= VEC_NUM_PIN_CHANGE;
			vecAddress_reg <= VEC_ADDR_PIN_CHANGE;
		end else begin
			vecNumber_reg  <= 4'h0;
			vecAddress_reg <= 16'h0000;
		end
	end
	assign vecNumber  = vecNumber_reg;
	assign vecAddress = vecAddress_reg;

	// sticky bus status of trigger events, set whatever the enables: bit0 dedicated, bit1 pin change
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irqStatus_reg <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == 0) ? (extEdgeHit | lowLevelActive) : pcHit) begin
					irqStatus_reg[i] <= 1'b1;
				end else if (wrEn && awAddr_reg == ADDR_IRQ_STATUS && wData_reg[i]) begin
					irqStatus_reg[i] <= 1'b0;
				end
			end
		end
	end
	assign irq = |(irqStatus_reg & irqMask_reg);

	// control registers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			senseSel_reg        <= RESET_SENSE;
			extEnable_reg       <= 1'b0;
			pcEnable_reg        <= 1'b0;
			globalIe_reg        <= 1'b0;
			pinChangeSelect_reg <= '0;
			irqMask_reg         <= 2'h0;
		end else if (wrEn) begin
			case (awAddr_reg)
				ADDR_MCU_CONTROL: begin
					senseSel_reg <= wData_reg[SENSE_SEL_HI_BIT:SENSE_SEL_LO_BIT];
				end
				ADDR_EXT_IRQ_ENABLES: begin
					extEnable_reg <= wData_reg[EXT_IRQ_FLAG_BIT];
					pcEnable_reg  <= wData_reg[PIN_CHANGE_FLAG_BIT];
				end
				ADDR_PIN_CHANGE_SEL: begin
					pinChangeSelect_reg <= wData_reg[PIN_CHANGE_COUNT-1:0];
				end
				ADDR_IRQ_MASK: begin
					irqMask_reg <= wData_reg[1:0];
				end
				ADDR_CORE_STATUS: begin
					globalIe_reg <= wData_reg[GLOBAL_IE_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// write channel capture; address and data in either order
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			awHeld_reg <= 1'b0;
			awAddr_reg <= 10'h000;
			wHeld_reg  <= 1'b0;
			wData_reg  <= RESET_BYTE;
			wLane0_reg <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= {s_axi_awaddr[9:2], 2'b00};
			end else if (doWrite) begin
				awHeld_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_reg  <= 1'b1;
				wData_reg  <= s_axi_wdata[7:0];
				wLane0_reg <= s_axi_wstrb[0];
			end else if (doWrite) begin
				wHeld_reg <= 1'b0;
			end
		end
	end
	assign s_axi_awready = ~awHeld_reg & ~bValid_reg;
	assign s_axi_wready  = ~wHeld_reg & ~bValid_reg;

	logic writeHit;
	always_comb begin
		case (awAddr_reg)
			ADDR_MCU_CONTROL, ADDR_EXT_IRQ_FLAGS, ADDR_EXT_IRQ_ENABLES,
			ADDR_PIN_CHANGE_SEL, ADDR_IRQ_STATUS, ADDR_IRQ_MASK, ADDR_CORE_STATUS: writeHit = 1'b1;
			default: writeHit = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			bValid_reg <= 1'b0;
			bResp_reg  <= RESP_OKAY;
		end else if (doWrite) begin
			bValid_reg <= 1'b1;
			bResp_reg  <= (writeHit && awAddr_reg[11-2 +: 1] == 1'b0) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bValid_reg <= 1'b0;
		end
	end
	assign s_axi_bvalid = bValid_reg;
	assign s_axi_bresp  = bResp_reg;

	// read side; reserved bits come back as zero
	assign s_axi_arready = ~rValid_reg;
	assign arTake        = s_axi_arvalid & ~rValid_reg;

	always_comb begin
		readByte = RESET_BYTE;
		readHit  = 1'b1;
		case ({s_axi_araddr[9:2], 2'b00})
			ADDR_MCU_CONTROL:     readByte[SENSE_SEL_HI_BIT:SENSE_SEL_LO_BIT] = senseSel_reg;
			ADDR_EXT_IRQ_FLAGS: begin
				readByte[EXT_IRQ_FLAG_BIT]    = extFlag_reg;
				readByte[PIN_CHANGE_FLAG_BIT] = pcFlag_reg;
			end
			ADDR_EXT_IRQ_ENABLES: begin
				readByte[EXT_IRQ_FLAG_BIT]    = extEnable_reg;
				readByte[PIN_CHANGE_FLAG_BIT] = pcEnable_reg;
			end
			ADDR_PIN_CHANGE_SEL:  readByte[PIN_CHANGE_COUNT-1:0] = pinChangeSelect_reg;
			ADDR_IRQ_STATUS:      readByte[1:0] = irqStatus_reg;
			ADDR_IRQ_MASK:        readByte[1:0] = irqMask_reg;
			ADDR_CORE_STATUS:     readByte[GLOBAL_IE_BIT] = globalIe_reg;
			default:              readHit = 1'b0;
		endcase
		if (s_axi_araddr[11:10] != 2'b00) begin
			readHit = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rValid_reg <= 1'b0;
			rData_reg  <= 32'h00000000;
			rResp_reg  <= RESP_OKAY;
		end else if (arTake) begin
			rValid_reg <= 1'b1;
			rData_reg  <= {24'h000000, readHit ? readByte : RESET_BYTE};
			rResp_reg  <= readHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rValid_reg <= 1'b0;
		end
	end
	assign s_axi_rvalid = rValid_reg;
	assign s_axi_rdata  = rData_reg;
	assign s_axi_rresp  = rResp_reg;

	// the pin-change tap of the dedicated pin is kept for symmetry of the sync bank
	logic unusedTap;
	assign unusedTap = syncTaps[PIN_CHANGE_COUNT];
endmodule // ext_pin_interrupt_sense
`default_nettype wire

// [verif/ext_pin_interrupt_checker.sv]
// port assertions for the external pin interrupt block
`timescale 1ns/100ps
`default_nettype none
module ext_pin_interrupt_checker
	import ext_irq_pkg::*;
(
	input wire logic                        sys_clk,
	input wire logic                        rst,
	input wire logic                        extIrqPin,
	input wire logic [PIN_CHANGE_COUNT-1:0] pinChangeInputs,
	input wire logic                        extVecAck,
	input wire logic                        pinChangeVecAck,
	input wire logic                        extIrqRequest,
	input wire logic                        pinChangeRequest,
	input wire logic [3:0]                  vecNumber,
	input wire logic [15:0]                 vecAddress,
	input wire logic                        irq,
	input wire logic                        s_axi_wvalid,
	input wire logic                        s_axi_wready,
	input wire logic                        s_axi_rvalid,
	input wire logic [31:0]                 s_axi_rdata
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	logic [PIN_CHANGE_COUNT:0] pinPrev;
	logic [3:0]                pinQuiet;
	logic [3:0]                wrQuiet;
	// cycles since any pin moved: a request may only rise shortly after a cause
	always_ff @(posedge sys_clk) begin
		pinPrev <= {extIrqPin, pinChangeInputs};
		if (rst || pinPrev != {extIrqPin, pinChangeInputs})
			pinQuiet <= 4'h0;
		else if (pinQuiet != 4'hF)
			pinQuiet <= pinQuiet + 4'h1;
	end
	always_ff @(posedge sys_clk) begin
		if (rst || (s_axi_wvalid && s_axi_wready))
			wrQuiet <= 4'h0;
		else if (wrQuiet != 4'hF)
			wrQuiet <= wrQuiet + 4'h1;
	end
	a_vec_ext_pin: assert property ($past(extIrqRequest) |->
		vecNumber == VEC_NUM_EXT_PIN && vecAddress == VEC_ADDR_EXT_PIN) else $error("wrong dedicated vector");
	a_vec_pin_change: assert property ($past(pinChangeRequest && !extIrqRequest) |->
		vecNumber == VEC_NUM_PIN_CHANGE && vecAddress == VEC_ADDR_PIN_CHANGE) else $error("wrong pc vector");
	a_vec_idle: assert property ($past(!extIrqRequest && !pinChangeRequest) |-> vecNumber == 4'h0)
		else $error("vector without request");
	a_pc_cause: assert property ($rose(pinChangeRequest) |-> pinQuiet <= 4'h6 || wrQuiet <= 4'h3)
		else $error("pc request without cause");
	a_ext_cause: assert property ($rose(extIrqRequest) |-> pinQuiet <= 4'h6 || wrQuiet <= 4'h3)
		else $error("ext request without cause");
	a_irq_cause: assert property ($rose(irq) |-> pinQuiet <= 4'h6 || wrQuiet <= 4'h3)
		else $error("irq without cause");
	a_pc_ack_clear: assert property (pinChangeVecAck && pinQuiet >= 4'h6 |=> !pinChangeRequest)
		else $error("pc ack did not clear");
	a_ext_ack_clear: assert property (extVecAck && extIrqPin && pinQuiet >= 4'h6 |=> !extIrqRequest)
		else $error("ext ack did not clear");
	a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
endmodule // ext_pin_interrupt_checker
bind ext_pin_interrupt_sense ext_pin_interrupt_checker chkInst (.*);
`default_nettype wire

// [verif/pin_source.sv]
// behavioural source driving the interrupt pins
`timescale 1ns/100ps
`default_nettype none
module pin_source
	import ext_irq_pkg::*;
(
	input  wire logic                        sys_clk,
	output logic                             extIrqPin,
	output logic [PIN_CHANGE_COUNT-1:0]      pinChangeInputs
);
	initial begin
		extIrqPin = 1'h1;
		pinChangeInputs = 6'h00;
	end
	// pins move 7 ns after a rising edge, clear of the sampling edge
	task automatic setPins(input logic e, input logic [PIN_CHANGE_COUNT-1:0] p);
		@(posedge sys_clk);
		#7;
		extIrqPin = e; // level held until the next call
		pinChangeInputs = p;
	endtask
endmodule // pin_source
`default_nettype wire

// [verif/tb.sv]
// self-checking bench for the external pin interrupt block
`timescale 1ns/100ps
`default_nettype none
module tb
	import ext_irq_pkg::*;
;
	logic        sys_clk = 1'h0;
	logic        rst = 1'h1;
	logic        extIrqPin;
	logic [5:0]  pinChangeInputs;
	logic        extVecAck = 1'h0;
	logic        pinChangeVecAck = 1'h0;
	logic        extIrqRequest, pinChangeRequest, irq;
	logic [3:0]  vecNumber;
	logic [15:0] vecAddress;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [31:0] rd;
	int          bad_count = 0, num_checks = 0, cycles = 0;
	ext_pin_interrupt_sense dut (.*);
	pin_source src (.sys_clk, .extIrqPin, .pinChangeInputs);
	always #20 sys_clk = ~sys_clk;
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			give_verdict;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic pin(input logic e, input logic [5:0] p);
		src.setPins(e, p);
		cyc(6);
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		s_axi_awaddr <= {2'h0, a};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
	endtask
	task automatic rdr(input logic [9:0] a);
		@(posedge sys_clk);
		s_axi_araddr <= {2'h0, a};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic ack(input logic pc);
		@(posedge sys_clk);
		if (pc)
			pinChangeVecAck <= 1'h1;
		else
			extVecAck <= 1'h1;
		@(posedge sys_clk);
		pinChangeVecAck <= 1'h0;
		extVecAck <= 1'h0;
		// flag clears at the edge that takes the pulse; look one cycle later
		@(posedge sys_clk);
	endtask
	task automatic scReset;
		logic [9:0] a[4] = '{ADDR_MCU_CONTROL, ADDR_EXT_IRQ_FLAGS, ADDR_EXT_IRQ_ENABLES, ADDR_PIN_CHANGE_SEL};
		foreach (a[i]) begin
			rdr(a[i]);
			chk(rd, 32'h0);
			chk(rsp, RESP_OKAY);
		end
		rdr(10'h000);
		chk(rd, 32'h0);
		chk(rsp, RESP_SLVERR);
		wr(ADDR_EXT_IRQ_ENABLES, 8'hFF);
		rdr(ADDR_EXT_IRQ_ENABLES);
		chk(rd, 32'h60);
		wr(ADDR_PIN_CHANGE_SEL, 8'hFF);
		rdr(ADDR_PIN_CHANGE_SEL);
		chk(rd, 32'h3F);
	endtask
	task automatic scModes;
		wr(ADDR_EXT_IRQ_ENABLES, 8'h40);
		wr(ADDR_CORE_STATUS, 8'h80);
		for (int m = 1; m < 4; m++) begin
			wr(ADDR_MCU_CONTROL, m[7:0]);
			pin(1'h0, 6'h00);
			chk(extIrqRequest, m != 3);
			wr(ADDR_EXT_IRQ_FLAGS, 8'h40);
			chk(extIrqRequest, 1'h0);
			pin(1'h1, 6'h00);
			chk(extIrqRequest, m != 2);
			wr(ADDR_EXT_IRQ_FLAGS, 8'h40);
		end
	endtask
	task automatic scMask;
		wr(ADDR_MCU_CONTROL, 8'h02);
		wr(ADDR_CORE_STATUS, 8'h00);
		pin(1'h0, 6'h00);
		chk(extIrqRequest, 1'h0);
		wr(ADDR_CORE_STATUS, 8'h80);
		chk(extIrqRequest, 1'h1);
		// vector is registered one cycle behind the request
		cyc(1);
		chk(vecNumber, VEC_NUM_EXT_PIN);
		chk(vecAddress, VEC_ADDR_EXT_PIN);
		// pin back high first so the acknowledge is the only clearing cause
		pin(1'h1, 6'h00);
		ack(1'h0);
		chk(extIrqRequest, 1'h0);
		src.setPins(1'h0, 6'h00);
		cyc(1);
		pin(1'h1, 6'h00);
		chk(extIrqRequest, 1'h1);
		// flag left set: level mode must clear it
	endtask
	task automatic scLevel;
		wr(ADDR_MCU_CONTROL, 8'h00);
		pin(1'h0, 6'h00);
		chk(extIrqRequest, 1'h1);
		cyc(8);
		chk(extIrqRequest, 1'h1);
		rdr(ADDR_EXT_IRQ_FLAGS);
		chk(rd, 32'h0);
		pin(1'h1, 6'h00);
		chk(extIrqRequest, 1'h0);
	endtask
	task automatic scPinChange;
		wr(ADDR_EXT_IRQ_ENABLES, 8'h20);
		wr(ADDR_PIN_CHANGE_SEL, 8'h05);
		pin(1'h1, 6'h02);
		chk(pinChangeRequest, 1'h0);
		pin(1'h1, 6'h06);
		chk(pinChangeRequest, 1'h1);
		chk(vecNumber, VEC_NUM_PIN_CHANGE);
		chk(vecAddress, VEC_ADDR_PIN_CHANGE);
		wr(ADDR_EXT_IRQ_FLAGS, 8'h00);
		chk(pinChangeRequest, 1'h1);
		wr(ADDR_IRQ_MASK, 8'h03);
		chk(irq, 1'h1);
		rdr(ADDR_IRQ_STATUS);
		chk(rd[1], 1'h1);
		wr(ADDR_IRQ_STATUS, 8'h03);
		chk(irq, 1'h0);
		wr(ADDR_EXT_IRQ_FLAGS, 8'h20);
		chk(pinChangeRequest, 1'h0);
		pin(1'h1, 6'h02);
		chk(pinChangeRequest, 1'h1);
		ack(1'h1);
		chk(pinChangeRequest, 1'h0);
	endtask
	initial begin
		cyc(4);
		rst <= 1'h0;
		scReset;
		scModes;
		scMask;
		scLevel;
		scPinChange;
		give_verdict;
	end
endmodule // tb
`default_nettype wire
